// ### hw/psc_ctrl.sv
// Host controller that drives the asynchronous page-mode memory pins.
// Summary of operation
// RULE_01: Data valid 70 ns after select.
// RULE_02: Lane data valid 70 ns after byte select.
// RULE_03: Page column data within 20 ns.
// RULE_04: Data valid 20 ns after output drive.
// RULE_05: Old data held 5 ns after address.
// RULE_06: Outputs float 8 ns after deselect.
// RULE_07: Lane floats 8 ns, drives after 10.
// RULE_08: Outputs float 8 ns after drive release.
// RULE_09: Page access select low at most 8 us.
// RULE_10: Write strobe low at most 8 us.
// RULE_11: Address 70 ns, cycle 70, strobe 46.
// RULE_12: Byte selects 70 ns before write end.
// RULE_13: Chip select 70 ns before write end.
// RULE_14: Write data 23 ns setup, zero hold.
// RULE_15: Strobe high 10 ns between writes.
// RULE_16: Select high 5 ns between writes.
// RULE_17: Memory waits 5 ns after write end.
// RULE_18: Deselect 5 ns before sleep request.
// RULE_19: Config strobe 10 to 500 ns after sleep.
// RULE_20: Sleep 10 us, then 150 us recovery.
// RULE_21: Wait 150 us after power-up.
// RULE_22: Config bit 4 picks sleep kind.
// RULE_23: Page reads only with config bit 7.
// RULE_24: Round least times up, longest down.
`timescale 1ns/10ps
module psc_ctrl (
    clk,
    nrst,
    ce,
    req_valid,
    req,
    req_ready,
    rsp_valid,
    rsp_data,
    page_on,
    pins,
    dq_in
);
    input wire logic clk;
    input wire logic nrst;
    input wire logic ce;
    input wire logic req_valid;
    input wire psc_pkg::psc_req_s req;
    output logic req_ready;
    output logic rsp_valid;
    output logic [psc_pkg::DATA_W-1:0] rsp_data;
    output logic page_on;
    output psc_pkg::psc_pins_s pins;
    input wire logic [psc_pkg::DATA_W-1:0] dq_in;

    // Counter word shared by the state and its limits.
    typedef logic [psc_pkg::CNT_W-1:0] psc_cnt_t;

    // All controller state in one packed struct.
    typedef struct packed {
        psc_pkg::psc_state_e state;
        psc_cnt_t cnt; // Wait counter in the state.
        psc_cnt_t sel_cnt; // Cycles select has been low.
        logic cfg_mode; // Write belongs to config load.
        logic page_en; // Host copy of config bit 7.
        logic page_open; // A page is open for reads.
        logic [psc_pkg::ADDR_W-1:0] page_addr;
        psc_pkg::psc_pins_s pins;
        logic rsp_valid;
        logic [psc_pkg::DATA_W-1:0] rsp_data;
    } psc_ctrl_s;

    psc_ctrl_s st_reg; // Registered state.
    psc_ctrl_s st_next; // Next state.
    logic [psc_pkg::DATA_W-1:0] dq_sync; // Data bus after two flops.

    // Reset image of the pins: everything idle, memory deselected.
    localparam psc_pkg::psc_pins_s PINS_IDLE = '{
        addr: '0,
        dq_out: '0,
        dq_oe: 1'h0,
        default: 1'h1
    };

    // Counter limits sized to the counter width.
    localparam psc_cnt_t K_READ = psc_cnt_t'(psc_pkg::C_READ + 2);
    localparam psc_cnt_t K_PAGE = psc_cnt_t'(psc_pkg::C_PAGE + 2);
    localparam psc_cnt_t K_WC = psc_cnt_t'(psc_pkg::C_WC);
    localparam psc_cnt_t K_WPH = psc_cnt_t'((psc_pkg::C_WPH >
        psc_pkg::C_CPH) ? psc_pkg::C_WPH : psc_pkg::C_CPH);
    localparam psc_cnt_t K_CDZZ = psc_cnt_t'(psc_pkg::C_CDZZ);
    localparam psc_cnt_t K_ZZWE = psc_cnt_t'(psc_pkg::C_ZZWE);
    localparam psc_cnt_t K_SEL = psc_cnt_t'(psc_pkg::C_SEL_MAX -
        psc_pkg::C_PAGE - 4);
    localparam psc_cnt_t K_ZZ = psc_cnt_t'(psc_pkg::C_ZZ);
    localparam psc_cnt_t K_REC = psc_cnt_t'(psc_pkg::C_REC);
    localparam psc_cnt_t K_PU = psc_cnt_t'(psc_pkg::C_PU);
    localparam psc_cnt_t K_HIZ = psc_cnt_t'(psc_pkg::C_HIZ);

    // Same page test, used by the idle decision.
    function automatic logic same_page(
        input logic [psc_pkg::ADDR_W-1:0] a,
        input logic [psc_pkg::ADDR_W-1:0] b
    );
        return a[psc_pkg::ADDR_W-1:psc_pkg::PAGE_COL_W] ==
            b[psc_pkg::ADDR_W-1:psc_pkg::PAGE_COL_W];
    endfunction

    // Data bus enters from a clockless device, so it is synchronised.
    psc_sync u_sync (
        .clk(clk),
        .nrst(nrst),
        .ce(ce),
        .din(dq_in),
        .dout(dq_sync)
    );

    // Next-state logic for the whole controller.
    always_comb begin
        st_next = st_reg;
        st_next.rsp_valid = 1'h0;
        st_next.cnt = st_reg.cnt + 1'h1;
        if (!st_reg.pins.chip_select_n) begin
            st_next.sel_cnt = st_reg.sel_cnt + 1'h1;
        end else begin
            st_next.sel_cnt = '0;
        end
        unique case (st_reg.state)
            // Hold off all access through the start-up wait.
            psc_pkg::PSC_ST_POWERUP: begin
                if (st_reg.cnt >= K_PU) begin // [RULE_21] [RULE_24]
                    st_next.state = psc_pkg::PSC_ST_IDLE;
                end
            end
            // Take a new request, or continue an open page.
            psc_pkg::PSC_ST_IDLE: begin
                st_next.cnt = '0;
                if (req_valid && req.cmd == psc_pkg::PSC_CMD_READ &&
                    st_reg.page_open && same_page(req.addr,
                    st_reg.page_addr)) begin
                    // Column change only; select stays low. [RULE_03]
                    st_next.pins.addr = req.addr;
                    st_next.state = psc_pkg::PSC_ST_PAGE;
                end else if (st_reg.page_open && req_valid) begin
                    // Close the page when another access waits, or at the select limit below.
                    st_next.pins = PINS_IDLE;
                    st_next.pins.addr = st_reg.pins.addr;
                    st_next.page_open = 1'h0;
                    st_next.state = psc_pkg::PSC_ST_WGAP;
                end else if (req_valid) begin
                    st_next.pins.addr = req.addr;
                    st_next.pins.chip_select_n = 1'h0;
                    st_next.pins.low_byte_select_n = ~req.be[0];
                    st_next.pins.high_byte_select_n = ~req.be[1];
                    st_next.cfg_mode = 1'h0;
                    unique case (req.cmd)
                        psc_pkg::PSC_CMD_READ: begin
                            st_next.pins.output_drive_n = 1'h0;
                            st_next.state = psc_pkg::PSC_ST_READ;
                        end
                        psc_pkg::PSC_CMD_WRITE: begin
                            // Address, selects, data and strobe all change on one edge.
                            st_next.pins.dq_out = req.wdata; // [RULE_14]
                            st_next.pins.dq_oe = 1'h1;
                            st_next.pins.write_strobe_n = 1'h0;
                            st_next.state = psc_pkg::PSC_ST_WRITE;
                        end
                        psc_pkg::PSC_CMD_CONFIG: begin
                            // Select stays high until the config strobe; config goes by address.
                            st_next.pins.chip_select_n = 1'h1;
                            st_next.pins.low_byte_select_n = 1'h1;
                            st_next.pins.high_byte_select_n = 1'h1;
                            st_next.cfg_mode = 1'h1;
                            st_next.state = psc_pkg::PSC_ST_CDZZ;
                        end
                        psc_pkg::PSC_CMD_SLEEP: begin
                            st_next.pins = PINS_IDLE;
                            st_next.pins.addr = st_reg.pins.addr;
                            st_next.state = psc_pkg::PSC_ST_CDZZ;
                        end
                        default: begin
                            // Wake with nothing asleep is a no-op.
                            st_next.pins = PINS_IDLE;
                            st_next.pins.addr = st_reg.pins.addr;
                            st_next.rsp_valid = 1'h1;
                        end
                    endcase
                end
            end
            // Random read: wait access time plus synchroniser delay.
            psc_pkg::PSC_ST_READ: begin
                if (st_reg.cnt >= K_READ) begin // [RULE_01] [RULE_02]
                    st_next.rsp_valid = 1'h1; // [RULE_04]
                    st_next.rsp_data = dq_sync;
                    st_next.cnt = '0;
                    if (st_reg.page_en) begin // [RULE_23]
                        st_next.page_open = 1'h1;
                        st_next.page_addr = st_reg.pins.addr;
                        st_next.state = psc_pkg::PSC_ST_IDLE;
                    end else begin
                        // Deselect and keep off the bus. [RULE_06]
                        st_next.pins = PINS_IDLE;
                        st_next.pins.addr = st_reg.pins.addr;
                        st_next.state = psc_pkg::PSC_ST_WGAP;
                    end
                end
            end
            // Page read: shorter access after a column change.
            psc_pkg::PSC_ST_PAGE: begin
                if (st_reg.cnt >= K_PAGE) begin // [RULE_03] [RULE_05]
                    st_next.rsp_valid = 1'h1;
                    st_next.rsp_data = dq_sync;
                    st_next.cnt = '0;
                    st_next.state = psc_pkg::PSC_ST_IDLE;
                end
            end
            // Write strobe low for a full cycle time, then end.
            psc_pkg::PSC_ST_WRITE: begin
                if (st_reg.cnt + 1'h1 >= K_WC) begin // [RULE_11] [RULE_24]
                    // Strobe, selects and data drop together. [RULE_12]
                    st_next.pins = PINS_IDLE; // [RULE_13] [RULE_14]
                    st_next.pins.addr = st_reg.pins.addr;
                    st_next.cnt = '0;
                    st_next.rsp_valid = 1'h1;
                    st_next.cfg_mode = 1'h0;
                    if (st_reg.cfg_mode) begin
                        st_next.page_en = st_reg.pins.addr[
                            psc_pkg::CFG_PAGE_BIT];
                    end
                    st_next.state = psc_pkg::PSC_ST_WGAP;
                end
            end
            // Gap after a write or read with everything high.
            psc_pkg::PSC_ST_WGAP: begin
                if (st_reg.cnt + 1'h1 >= K_WPH &&
                    st_reg.cnt + 1'h1 >= K_HIZ) begin // [RULE_15] [RULE_16]
                    st_next.cnt = '0;
                    st_next.state = psc_pkg::PSC_ST_IDLE; // [RULE_17]
                end
            end
            // Keep select high before the sleep request falls.
            psc_pkg::PSC_ST_CDZZ: begin
                if (st_reg.cnt + 1'h1 >= K_CDZZ) begin // [RULE_18]
                    st_next.pins.sleep_request_n = 1'h0;
                    st_next.cnt = '0;
                    if (st_reg.cfg_mode) begin
                        st_next.state = psc_pkg::PSC_ST_CFG_WAIT;
                    end else begin
                        st_next.state = psc_pkg::PSC_ST_SLEEP;
                    end
                end
            end
            // Config load: strobe falls after the least delay. [RULE_19]
            psc_pkg::PSC_ST_CFG_WAIT: begin
                if (st_reg.cnt + 1'h1 >= K_ZZWE) begin
                    st_next.pins.chip_select_n = 1'h0;
                    st_next.pins.write_strobe_n = 1'h0;
                    st_next.cnt = '0;
                    st_next.state = psc_pkg::PSC_ST_WRITE;
                end
            end
            // Asleep until the least pulse passed and wake is asked.
            psc_pkg::PSC_ST_SLEEP: begin
                if (st_reg.cnt >= K_ZZ) begin
                    st_next.cnt = K_ZZ;
                    if (req_valid &&
                        req.cmd == psc_pkg::PSC_CMD_WAKE) begin // [RULE_20]
                        st_next.pins.sleep_request_n = 1'h1;
                        st_next.cnt = '0;
                        st_next.state = psc_pkg::PSC_ST_RECOVER;
                    end
                end
            end
            // Recovery wait; kept even for the retention sleep [RULE_22].
            psc_pkg::PSC_ST_RECOVER: begin
                if (st_reg.cnt >= K_REC) begin // [RULE_20]
                    st_next.rsp_valid = 1'h1;
                    st_next.state = psc_pkg::PSC_ST_IDLE;
                end
            end
            default: begin
                st_next = st_reg;
                st_next.state = psc_pkg::PSC_ST_IDLE;
            end
        endcase
        // Close a page before select low reaches its limit. [RULE_09]
        if (st_reg.page_open && st_reg.state == psc_pkg::PSC_ST_IDLE &&
            st_reg.sel_cnt >= K_SEL) begin
            st_next.pins = PINS_IDLE;
            st_next.pins.addr = st_reg.pins.addr;
            st_next.page_open = 1'h0;
            st_next.cnt = '0;
            st_next.state = psc_pkg::PSC_ST_WGAP;
        end
    end

    // State register; a write lasts far below the strobe limit [RULE_10].
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_reg <= '0;
            st_reg.state <= psc_pkg::PSC_ST_POWERUP;
            st_reg.pins <= PINS_IDLE;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    // Requests other than wake are taken in idle when nothing must be closed first, and wake only in sleep.
    always_comb begin
        req_ready = 1'h0;
        if (st_reg.state == psc_pkg::PSC_ST_IDLE) begin
            if (req.cmd == psc_pkg::PSC_CMD_READ && st_reg.page_open) begin
                // Refused when the select limit closes the page now.
                req_ready = same_page(req.addr, st_reg.page_addr) &&
                    st_reg.sel_cnt < K_SEL; // [RULE_09]
            end else begin
                req_ready = !st_reg.page_open && req.cmd !=
                    psc_pkg::PSC_CMD_WAKE;
            end
        end else if (st_reg.state == psc_pkg::PSC_ST_SLEEP) begin
            req_ready = (st_reg.cnt >= K_ZZ) &&
                req.cmd == psc_pkg::PSC_CMD_WAKE;
        end
        req_ready = req_ready && ce;
    end

    assign rsp_valid = st_reg.rsp_valid;
    assign rsp_data = st_reg.rsp_data;
    assign page_on = st_reg.page_en;
    assign pins = st_reg.pins;
endmodule

// ### shared/psc_pkg.sv
// Package with timing constants, pin groups and states for the memory controller.
package psc_pkg;

    // Clock period in picoseconds (10 MHz).
    localparam int unsigned CLK_PS = 100000;

    // Memory timings, in the units given by each name.
    localparam int unsigned T_READ_NS = 70; // Access.
    localparam int unsigned T_OE_NS = 20; // Drive to data.
    localparam int unsigned T_PAGE_NS = 20; // Page access.
    localparam int unsigned T_HIZ_NS = 8; // Release.
    localparam int unsigned T_WC_NS = 70; // Write cycle.
    localparam int unsigned T_WP_NS = 46; // Strobe low.
    localparam int unsigned T_DW_NS = 23; // Data setup.
    localparam int unsigned T_WPH_NS = 10; // Strobe high.
    localparam int unsigned T_CPH_NS = 5; // Select high.
    localparam int unsigned T_CDZZ_NS = 5; // Deselect to sleep.
    localparam int unsigned T_ZZWE_MIN_NS = 10; // Sleep to strobe.
    localparam int unsigned T_ZZWE_MAX_NS = 500; // Its limit.
    localparam int unsigned T_SEL_MAX_US = 8; // Longest low.
    localparam int unsigned T_ZZ_US = 10; // Sleep pulse.
    localparam int unsigned T_REC_US = 150; // Recovery.
    localparam int unsigned T_PU_US = 150; // Power-up.

    // Cycle counts: least times round up, longest times round down.
    function automatic int unsigned up_ns(input int unsigned ns);
        int unsigned c;
        c = (ns * 1000 + CLK_PS - 1) / CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction

    function automatic int unsigned dn_ns(input int unsigned ns);
        int unsigned c;
        c = (ns * 1000) / CLK_PS;
        return (c < 1) ? 1 : c;
    endfunction

    // Read waits are least waits for the host, so they round up.
    localparam int unsigned C_READ = up_ns(T_READ_NS);
    localparam int unsigned C_PAGE = up_ns(T_PAGE_NS);
    localparam int unsigned C_HIZ = up_ns(T_HIZ_NS);
    localparam int unsigned C_WC = up_ns(T_WC_NS);
    localparam int unsigned C_WP = up_ns(T_WP_NS);
    localparam int unsigned C_DW = up_ns(T_DW_NS);
    localparam int unsigned C_WPH = up_ns(T_WPH_NS);
    localparam int unsigned C_CPH = up_ns(T_CPH_NS);
    localparam int unsigned C_CDZZ = up_ns(T_CDZZ_NS);
    localparam int unsigned C_ZZWE = up_ns(T_ZZWE_MIN_NS);
    localparam int unsigned C_ZZWE_MAX = dn_ns(T_ZZWE_MAX_NS);
    localparam int unsigned C_SEL_MAX = dn_ns(T_SEL_MAX_US * 1000);
    localparam int unsigned C_ZZ = up_ns(T_ZZ_US * 1000);
    localparam int unsigned C_REC = up_ns(T_REC_US * 1000);
    localparam int unsigned C_PU = up_ns(T_PU_US * 1000);

    // Field layout of the memory.
    localparam int unsigned ADDR_W = 21;
    localparam int unsigned DATA_W = 16;
    localparam int unsigned CNT_W = 16;
    localparam int unsigned CFG_PAGE_BIT = 7;
    localparam int unsigned CFG_SLEEP_BIT = 4;
    localparam int unsigned PAGE_COL_W = 4;

    // Commands from the user side.
    typedef enum logic [2:0] {
        PSC_CMD_READ,
        PSC_CMD_WRITE,
        PSC_CMD_CONFIG,
        PSC_CMD_SLEEP,
        PSC_CMD_WAKE
    } psc_cmd_e;

    // A user request.
    typedef struct packed {
        psc_cmd_e cmd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
        logic [1:0] be;
    } psc_req_s;

    // Memory pins driven by the controller; the data bus is split.
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic chip_select_n;
        logic output_drive_n;
        logic write_strobe_n;
        logic low_byte_select_n;
        logic high_byte_select_n;
        logic sleep_request_n;
        logic [DATA_W-1:0] dq_out;
        logic dq_oe;
    } psc_pins_s;

    // Controller states.
    typedef enum logic [3:0] {
        PSC_ST_POWERUP,
        PSC_ST_IDLE,
        PSC_ST_READ,
        PSC_ST_PAGE,
        PSC_ST_WRITE,
        PSC_ST_WGAP,
        PSC_ST_CDZZ,
        PSC_ST_CFG_WAIT,
        PSC_ST_SLEEP,
        PSC_ST_RECOVER
    } psc_state_e;

endpackage

// ### hw/psc_sync.sv
// Two-flop synchroniser for the memory data bus.
`timescale 1ns/10ps
module psc_sync (
    clk,
    nrst,
    ce,
    din,
    dout
);
    input wire logic clk;
    input wire logic nrst;
    input wire logic ce;
    input wire logic [psc_pkg::DATA_W-1:0] din;
    output logic [psc_pkg::DATA_W-1:0] dout;

    // Both stages held in one packed state.
    typedef struct packed {
        logic [psc_pkg::DATA_W-1:0] s1;
        logic [psc_pkg::DATA_W-1:0] s2;
    } psc_sync_s;

    psc_sync_s st_reg; // Registered stages.
    psc_sync_s st_next; // Next value of the stages.

    // First stage feeds only the second; the memory has no clock.
    always_comb begin
        st_next.s1 = din;
        st_next.s2 = st_reg.s1;
    end

    // Registers with synchronous clear and clock enable.
    always_ff @(posedge clk) begin
        if (!nrst) begin
            st_reg <= '0;
        end else if (ce) begin
            st_reg <= st_next;
        end
    end

    assign dout = st_reg.s2;
endmodule

// ### tb/psc_chk.sv
// Checker for the pin timing of the memory controller.
`timescale 1ns/10ps
module psc_chk (
    clk,
    nrst,
    pins
);
    input wire logic clk;
    input wire logic nrst;
    input wire psc_pkg::psc_pins_s pins;
    int unsigned cs_cnt, we_cnt, sl_cnt, q_cnt; // Low and quiet times.
    logic cfg_seen, sl_prev; // A strobe came while sleep was low.
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // Quiet time restarts at reset and at each true sleep exit.
    always_ff @(posedge clk) begin
        cs_cnt <= pins.chip_select_n ? 0 : cs_cnt + 1;
        we_cnt <= pins.write_strobe_n ? 0 : we_cnt + 1;
        sl_cnt <= pins.sleep_request_n ? 0 : sl_cnt + 1;
        cfg_seen <= !pins.sleep_request_n && (cfg_seen
            || !pins.write_strobe_n);
        sl_prev <= pins.sleep_request_n;
        if (!nrst || (pins.sleep_request_n && !sl_prev && !cfg_seen)) begin
            q_cnt <= 1;
        end else if (q_cnt < 9000) begin
            q_cnt <= q_cnt + 1;
        end
    end
    sel_low_max_a: assert property (cs_cnt < psc_pkg::C_SEL_MAX)
        else $error("select held low too long");
    strobe_max_a: assert property (we_cnt < psc_pkg::C_SEL_MAX)
        else $error("strobe held low too long");
    write_hold_a: assert property (!pins.write_strobe_n &&
        $past(!pins.write_strobe_n) |-> $stable(pins.addr)
        && $stable(pins.low_byte_select_n))
        else $error("address moved during a write");
    sel_before_end_a: assert property ($rose(pins.write_strobe_n)
        |-> $past(!pins.chip_select_n)) else $error("write without select");
    data_setup_a: assert property ($rose(pins.write_strobe_n) &&
        $past(pins.sleep_request_n) |-> $past(pins.dq_oe))
        else $error("write data not driven");
    strobe_gap_a: assert property ($rose(pins.write_strobe_n)
        |=> pins.write_strobe_n) else $error("strobe high too short");
    sel_gap_a: assert property ($rose(pins.chip_select_n)
        |=> pins.chip_select_n) else $error("select high too short");
    sleep_desel_a: assert property ($fell(pins.sleep_request_n)
        |-> $past(pins.chip_select_n)) else $error("sleep while selected");
    cfg_window_a: assert property ($fell(pins.write_strobe_n) &&
        !pins.sleep_request_n |-> sl_cnt >= psc_pkg::C_ZZWE
        && sl_cnt <= psc_pkg::C_ZZWE_MAX) else $error("config strobe late");
    sleep_len_a: assert property ($rose(pins.sleep_request_n)
        && !cfg_seen |-> sl_cnt >= psc_pkg::C_ZZ)
        else $error("sleep pulse too short");
    quiet_wait_a: assert property ($fell(pins.chip_select_n)
        |-> q_cnt >= psc_pkg::C_PU) else $error("access too early");
    cover property ($rose(pins.write_strobe_n) && pins.sleep_request_n);
    cover property ($fell(pins.write_strobe_n) && !pins.sleep_request_n);
    cover property ($rose(pins.sleep_request_n) && !cfg_seen);
endmodule
bind psc_ctrl psc_chk u_psc_chk (.clk(clk), .nrst(nrst), .pins(pins));

// ### tb/psc_mem_model.sv
// Behavioural model of the asynchronous page-mode memory.
`timescale 1ns/10ps
module psc_mem_model (
    pins,
    dq
);
    input wire psc_pkg::psc_pins_s pins;
    output logic [15:0] dq = 16'h0000;
    logic [15:0] mem [logic [20:0]]; // Sparse storage.
    logic [20:0] cfg = 21'h000070; // Power-up word: page reads off.
    logic [15:0] w, q;
    logic ok;
    logic cfgw = 1'b0; // The sleep pulse carried a config write.
    realtime t_sel = 0, t_oe = 0, t_adr = 0, t_we = 0;
    psc_pkg::psc_pins_s p = '1; // Pins before the latest change.
    // The pin group changes as one, so edges are found against p.
    always @(pins) begin
        if (p.chip_select_n && !pins.chip_select_n) t_sel = $realtime;
        if ((p.low_byte_select_n && !pins.low_byte_select_n) ||
            (p.high_byte_select_n && !pins.high_byte_select_n))
            t_sel = $realtime;
        if (p.output_drive_n && !pins.output_drive_n) t_oe = $realtime;
        if (p.addr !== pins.addr) begin
            t_adr = (cfg[7] && p.addr[20:4] === pins.addr[20:4]) ?
                $realtime - 50 : $realtime;
        end
        if (!p.write_strobe_n && pins.write_strobe_n) begin
            t_we = $realtime;
            if (!p.sleep_request_n) begin
                cfg = p.addr;
                cfgw = 1'b1;
            end else if (!p.chip_select_n) begin
                w = mem.exists(p.addr) ? mem[p.addr] : 16'h0000;
                if (!p.low_byte_select_n) w[7:0] = p.dq_out[7:0];
                if (!p.high_byte_select_n) w[15:8] = p.dq_out[15:8];
                mem[p.addr] = w;
            end
        end
        // Leaving deep sleep loses the array contents.
        if (!p.sleep_request_n && pins.sleep_request_n) begin
            if (!cfgw && !cfg[4]) mem.delete();
            cfgw = 1'b0;
        end
        p = pins;
    end
    // Unsettled lanes toggle, so an early sample fails.
    always #5 begin
        ok = !pins.chip_select_n && !pins.output_drive_n &&
            pins.write_strobe_n && pins.sleep_request_n &&
            $realtime - t_sel >= 70 && $realtime - t_oe >= 20 &&
            $realtime - t_adr >= 70 && $realtime - t_we >= 5;
        q = mem.exists(pins.addr) ? mem[pins.addr] : 16'h0000;
        dq[7:0] <= ok && !pins.low_byte_select_n ? q[7:0] : ~dq[7:0];
        dq[15:8] <= ok && !pins.high_byte_select_n ? q[15:8] : ~dq[15:8];
    end
endmodule

// ### tb/psc_ctrl_tb.sv
// Self-checking bench for the memory controller.
`timescale 1ns/10ps
module psc_ctrl_tb;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ce = 1'b1;
    logic req_valid = 1'b0;
    psc_pkg::psc_req_s req = '0;
    logic req_ready, rsp_valid, page_on;
    logic [15:0] rsp_data, mem_dq, dq_in, got;
    psc_pkg::psc_pins_s pins;
    logic [15:0] ref_mem [logic [20:0]]; // Expected memory contents.
    logic [20:0] a;
    int fails = 0;
    int check_count = 0;
    int cyc = 0;
    always #50 clk = ~clk;
    // The shared data bus: the controller wins while it drives.
    assign dq_in = pins.dq_oe ? pins.dq_out : mem_dq;
    psc_ctrl u_psc_ctrl (.clk(clk), .nrst(nrst), .ce(ce),
        .req_valid(req_valid), .req(req), .req_ready(req_ready),
        .rsp_valid(rsp_valid), .rsp_data(rsp_data), .page_on(page_on),
        .pins(pins), .dq_in(dq_in));
    psc_mem_model u_psc_mem_model (.pins(pins), .dq(mem_dq));
    function automatic logic [15:0] exp_word(input logic [20:0] ad);
        return ref_mem.exists(ad) ? ref_mem[ad] : 16'h0000;
    endfunction
    task automatic check_data(input string what, input logic [15:0] e,
        input logic [15:0] s);
        check_count++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, s);
        end
    endtask
    task automatic check_bit(input string what, input logic e, input logic s);
        check_count++;
        if (s !== e) begin
            fails++;
            $display("CHECK FAILED %s expected %b seen %b", what, e, s);
        end
    endtask
    // Hold the request until it is taken, then, when rsp is set, await the answer pulse.
    task automatic xfer(input psc_pkg::psc_cmd_e c, input logic [20:0] ad,
        input logic [15:0] wd, input logic [1:0] be, input bit rsp);
        @(posedge clk);
        req_valid <= 1'b1;
        req <= '{c, ad, wd, be};
        do @(negedge clk); while (req_ready !== 1'b1);
        @(posedge clk);
        req_valid <= 1'b0;
        if (rsp) begin
            do @(negedge clk); while (rsp_valid !== 1'b1);
            got = rsp_data;
        end
    endtask
    task automatic wr(input logic [20:0] ad, input logic [15:0] wd,
        input logic [1:0] be);
        logic [15:0] m;
        m = exp_word(ad);
        if (be[0]) m[7:0] = wd[7:0];
        if (be[1]) m[15:8] = wd[15:8];
        ref_mem[ad] = m;
        xfer(psc_pkg::PSC_CMD_WRITE, ad, wd, be, 1'b1);
    endtask
    task automatic rd(input logic [20:0] ad);
        xfer(psc_pkg::PSC_CMD_READ, ad, 16'h0000, 2'b11, 1'b1);
        check_data("read data", exp_word(ad), got);
    endtask
    task automatic nap(input logic [20:0] cfg_word);
        xfer(psc_pkg::PSC_CMD_CONFIG, cfg_word, '0, '0, 1'b1);
        xfer(psc_pkg::PSC_CMD_SLEEP, '0, '0, '0, 1'b0);
        xfer(psc_pkg::PSC_CMD_WAKE, '0, '0, '0, 1'b1);
    endtask
    task automatic summarize();
        if (fails == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // A hang counts as a mismatch and closes the run.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            summarize();
        end
    end
    initial begin
        void'($urandom(68));
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        wr(21'h000000, 16'hA55A, 2'b11);
        wr(21'h1FFFFF, 16'h1234, 2'b01);
        for (int i = 0; i < 30; i++) begin
            a = 21'($urandom_range(0, 47));
            if ($urandom_range(0, 1) == 1) begin
                wr(a, 16'($urandom), 2'($urandom_range(1, 3)));
            end else begin
                rd(a);
            end
        end
        rd(21'h1FFFFF);
        // Freeze the clock enable in the middle of a read.
        fork
            rd(21'h000003);
            begin
                repeat (4) @(posedge clk);
                ce <= 1'b0;
                repeat (3) @(posedge clk);
                ce <= 1'b1;
            end
        join
        nap(21'h000090);
        check_bit("page flag", 1'b1, page_on);
        rd(21'h000000);
        for (int i = 0; i < 20; i++) rd(21'h000010 + 21'(i % 16));
        rd(21'h000005);
        nap(21'h000000);
        check_bit("page flag", 1'b0, page_on);
        ref_mem.delete();
        rd(21'h000000);
        wr(21'h000007, 16'hBEEF, 2'b10);
        @(posedge clk);
        nrst <= 1'b0;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        rd(21'h000007);
        summarize();
    end
endmodule
